//--- inc/page_stack_pkg.sv
package page_stack_pkg;
  localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h81;
  localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'h84;
  localparam logic [7:0] ADDR_STACK_MIDDLE = 8'h85;
  localparam logic [7:0] ADDR_STACK_BOTTOM = 8'h86;
  localparam int ENABLE_BIT = 0;
  localparam logic RST_ENABLE = 1'h1;
  localparam logic [7:0] RST_ENTRY = 8'h00;
  localparam logic [7:0] PAGE_CONVERTER = 8'h02;
  localparam logic [7:0] PAGE_COUNTER_ARRAY = 8'h00;
  localparam logic [7:0] EMPTY_PAGE = 8'h00;
  localparam int NUM_ENTRIES = 3;
  typedef enum logic [1:0] {
    SRC_CONVERTER,
    SRC_COUNTER_ARRAY,
    SRC_OTHER
  } irq_source_t;
endpackage

//--- src/page_entry.sv
`timescale 1ns/1ns
module page_entry (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hw_load_in,
  input wire logic [7:0] hw_value_in,
  input wire logic sw_write_in,
  input wire logic [7:0] sw_value_in,
  output logic [7:0] value_out
);
  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  always_comb begin
    nxt_value = value_ff;
    if (hw_load_in) begin
      nxt_value = hw_value_in;
    end else if (sw_write_in) begin
      nxt_value = sw_value_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_ff <= page_stack_pkg::RST_ENTRY;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value_out = value_ff;
endmodule

//--- src/page_context_stack.sv
`timescale 1ns/1ns
module page_context_stack (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic IRQ_ENTRY_IN,
  input wire logic [1:0] IRQ_SOURCE_IN,
  input wire logic [7:0] IRQ_PAGE_IN,
  input wire logic IRQ_RETURN_IN,
  input wire logic REG_WRITE_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_HIT_OUT,
  output logic [7:0] ACTIVE_PAGE_OUT,
  output logic AUTO_PAGE_ENABLE_OUT
);
  // what the stack does in a cycle
  typedef enum logic [1:0] {
    OP_HOLD,
    OP_PUSH,
    OP_POP
  } stack_op_t;

  // which register the address selects
  typedef enum logic [2:0] {
    REG_NONE,
    REG_CONTROL,
    REG_ACTIVE,
    REG_MIDDLE,
    REG_BOTTOM
  } reg_select_t;

  stack_op_t stack_op;
  reg_select_t reg_select;
  logic auto_page_enable_ff;
  logic nxt_auto_page_enable;
  logic push;
  logic pop;
  logic sel_control;
  logic sel_active;
  logic sel_middle;
  logic sel_bottom;
  logic wr_control;
  logic wr_active;
  logic wr_middle;
  logic wr_bottom;
  logic [7:0] source_page;
  logic [7:0] active_page;
  logic [7:0] middle_page;
  logic [7:0] bottom_page;
  logic hw_load_active;
  logic [7:0] hw_active;
  logic hw_load_middle;
  logic [7:0] hw_middle;
  logic hw_load_bottom;
  logic [7:0] hw_bottom;
  logic [7:0] entry_value [page_stack_pkg::NUM_ENTRIES];
  logic [7:0] hw_value [page_stack_pkg::NUM_ENTRIES];
  logic hw_load [page_stack_pkg::NUM_ENTRIES];
  logic sw_write [page_stack_pkg::NUM_ENTRIES];
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic hit_ff;
  logic nxt_hit;

  // register decode, the same on every page
  always_comb begin
    reg_select = REG_NONE;
    unique case (REG_ADDR_IN)
      page_stack_pkg::ADDR_PAGE_CONTROL: begin
        reg_select = REG_CONTROL;
      end
      page_stack_pkg::ADDR_ACTIVE_PAGE: begin
        reg_select = REG_ACTIVE;
      end
      page_stack_pkg::ADDR_STACK_MIDDLE: begin
        reg_select = REG_MIDDLE;
      end
      page_stack_pkg::ADDR_STACK_BOTTOM: begin
        reg_select = REG_BOTTOM;
      end
      default: begin
        reg_select = REG_NONE;
      end
    endcase
  end

  assign sel_control = (reg_select == REG_CONTROL);
  assign sel_active = (reg_select == REG_ACTIVE);
  assign sel_middle = (reg_select == REG_MIDDLE);
  assign sel_bottom = (reg_select == REG_BOTTOM);

  // a write touches only the one register it addresses
  always_comb begin
    wr_control = 1'b0;
    wr_active = 1'b0;
    wr_middle = 1'b0;
    wr_bottom = 1'b0;
    if (REG_WRITE_IN) begin
      wr_control = sel_control;
      wr_active = sel_active;
      wr_middle = sel_middle;
      wr_bottom = sel_bottom;
    end
  end

  // stack moves only on entry or return, and only when enabled
  assign push = IRQ_ENTRY_IN && auto_page_enable_ff;
  // an entry wins over a return in the same cycle
  assign pop = IRQ_RETURN_IN && auto_page_enable_ff && !push;

  // at most one stack operation per cycle
  always_comb begin
    stack_op = OP_HOLD;
    if (push) begin
      stack_op = OP_PUSH;
    end else if (pop) begin
      stack_op = OP_POP;
    end
  end

  // page of the interrupting source
  always_comb begin
    source_page = IRQ_PAGE_IN;
    unique case (page_stack_pkg::irq_source_t'(IRQ_SOURCE_IN))
      page_stack_pkg::SRC_CONVERTER: begin
        source_page = page_stack_pkg::PAGE_CONVERTER;
      end
      page_stack_pkg::SRC_COUNTER_ARRAY: begin
        source_page = page_stack_pkg::PAGE_COUNTER_ARRAY;
      end
      page_stack_pkg::SRC_OTHER: begin
        source_page = IRQ_PAGE_IN;
      end
      default: begin
        source_page = IRQ_PAGE_IN;
      end
    endcase
  end

  // current entry values, top to bottom
  assign active_page = entry_value[0];
  assign middle_page = entry_value[1];
  assign bottom_page = entry_value[2];

  // top entry: source page on entry, middle entry on return
  always_comb begin
    hw_load_active = 1'b0;
    hw_active = active_page;
    unique case (stack_op)
      OP_PUSH: begin
        hw_load_active = 1'b1;
        hw_active = source_page;
      end
      OP_POP: begin
        hw_load_active = 1'b1;
        hw_active = middle_page;
      end
      OP_HOLD: begin
        hw_load_active = 1'b0;
      end
    endcase
  end

  // middle entry: old top on entry, bottom entry on return
  always_comb begin
    hw_load_middle = 1'b0;
    hw_middle = middle_page;
    unique case (stack_op)
      OP_PUSH: begin
        hw_load_middle = 1'b1;
        hw_middle = active_page;
      end
      OP_POP: begin
        hw_load_middle = 1'b1;
        hw_middle = bottom_page;
      end
      OP_HOLD: begin
        hw_load_middle = 1'b0;
      end
    endcase
  end

  // bottom entry: old middle on entry
  // it empties on return, so a later return hands down an empty page
  always_comb begin
    hw_load_bottom = 1'b0;
    hw_bottom = bottom_page;
    unique case (stack_op)
      OP_PUSH: begin
        hw_load_bottom = 1'b1;
        hw_bottom = middle_page;
      end
      OP_POP: begin
        hw_load_bottom = 1'b1;
        hw_bottom = page_stack_pkg::EMPTY_PAGE;
      end
      OP_HOLD: begin
        hw_load_bottom = 1'b0;
      end
    endcase
  end

  // controls for the three entry instances
  always_comb begin
    hw_load[0] = hw_load_active;
    hw_value[0] = hw_active;
    sw_write[0] = wr_active;
    hw_load[1] = hw_load_middle;
    hw_value[1] = hw_middle;
    sw_write[1] = wr_middle;
    hw_load[2] = hw_load_bottom;
    hw_value[2] = hw_bottom;
    sw_write[2] = wr_bottom;
  end

  // entry 0 is the active page, 1 the middle, 2 the bottom
  genvar i;
  generate
    for (i = 0; i < page_stack_pkg::NUM_ENTRIES; i++) begin : g_entry
      page_entry u_entry (
        .clk_in(CLOCK_IN),
        .rst_in(RST_IN),
        .hw_load_in(hw_load[i]),
        .hw_value_in(hw_value[i]),
        .sw_write_in(sw_write[i]),
        .sw_value_in(REG_WDATA_IN),
        .value_out(entry_value[i])
      );
    end
  endgenerate

  // only bit 0 of the control register is stored
  always_comb begin
    nxt_auto_page_enable = auto_page_enable_ff;
    if (wr_control) begin
      nxt_auto_page_enable = REG_WDATA_IN[page_stack_pkg::ENABLE_BIT];
    end
  end

  // enable register
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      auto_page_enable_ff <= page_stack_pkg::RST_ENABLE;
    end else begin
      auto_page_enable_ff <= nxt_auto_page_enable;
    end
  end

  // read data holds what the register held when it was addressed
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_select)
      REG_CONTROL: begin
        nxt_rdata = {7'h00, auto_page_enable_ff};
      end
      REG_ACTIVE: begin
        nxt_rdata = active_page;
      end
      REG_MIDDLE: begin
        nxt_rdata = middle_page;
      end
      REG_BOTTOM: begin
        nxt_rdata = bottom_page;
      end
      REG_NONE: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // read data register
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // hit marks an address that this block answers
  always_comb begin
    nxt_hit = 1'b1;
    if (reg_select == REG_NONE) begin
      nxt_hit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA_OUT = rdata_ff;
  assign REG_HIT_OUT = hit_ff;
  assign ACTIVE_PAGE_OUT = active_page;
  assign AUTO_PAGE_ENABLE_OUT = auto_page_enable_ff;
endmodule

//--- tb/page_context_stack_properties.sv
`timescale 1ns/1ns
module page_stack_checker (
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  input wire logic IRQ_ENTRY_IN,
  input wire logic IRQ_RETURN_IN,
  input wire logic REG_WRITE_IN,
  input wire logic REG_HIT_OUT,
  input wire logic AUTO_PAGE_ENABLE_OUT,
  input wire logic [1:0] IRQ_SOURCE_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic [7:0] ACTIVE_PAGE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  logic go, q, rd, map;
  assign go = IRQ_ENTRY_IN && AUTO_PAGE_ENABLE_OUT;
  assign q = !IRQ_ENTRY_IN && !IRQ_RETURN_IN;
  assign rd = q && !REG_WRITE_IN;
  assign map = REG_ADDR_IN inside {8'h81, [8'h84:8'h86]};
  conv_page_a: assert property (go && IRQ_SOURCE_IN == 2'h0 |=>
    ACTIVE_PAGE_OUT == 8'h02) else $error("converter page");
  count_page_a: assert property (go && IRQ_SOURCE_IN == 2'h1 |=>
    ACTIVE_PAGE_OUT == 8'h00) else $error("counter page");
  off_hold_a: assert property (!AUTO_PAGE_ENABLE_OUT &&
    !REG_WRITE_IN |=> $stable(ACTIVE_PAGE_OUT)) else $error("paged off");
  page_wr_a: assert property (q && REG_WRITE_IN &&
    REG_ADDR_IN == 8'h84 |=> ACTIVE_PAGE_OUT == $past(REG_WDATA_IN))
    else $error("page write");
  idle_hold_a: assert property (rd |=> $stable(ACTIVE_PAGE_OUT) &&
    $stable(AUTO_PAGE_ENABLE_OUT)) else $error("idle change");
  ctrl_rsv_a: assert property (rd && REG_ADDR_IN == 8'h81 |=>
    REG_HIT_OUT && REG_RDATA_OUT[7:1] == 7'h00) else $error("reserved");
  page_rd_a: assert property (rd && REG_ADDR_IN == 8'h84 |=>
    REG_RDATA_OUT == ACTIVE_PAGE_OUT) else $error("page read");
  unmapped_a: assert property (!map |=> !REG_HIT_OUT &&
    REG_RDATA_OUT == 8'h00) else $error("unmapped");
  pop_restore_a: assert property (rd && REG_ADDR_IN == 8'h85 ##1
    IRQ_RETURN_IN && q == 1'h0 && !IRQ_ENTRY_IN && AUTO_PAGE_ENABLE_OUT
    |=> ACTIVE_PAGE_OUT == $past(REG_RDATA_OUT)) else $error("pop page");
  cover property (go && REG_WRITE_IN);
  cover property (IRQ_RETURN_IN && AUTO_PAGE_ENABLE_OUT);
  cover property (!AUTO_PAGE_ENABLE_OUT && IRQ_ENTRY_IN);
endmodule
bind page_context_stack page_stack_checker chk_i (
  .CLOCK_IN(CLOCK_IN),
  .RST_IN(RST_IN),
  .IRQ_ENTRY_IN(IRQ_ENTRY_IN),
  .IRQ_RETURN_IN(IRQ_RETURN_IN),
  .REG_WRITE_IN(REG_WRITE_IN),
  .REG_HIT_OUT(REG_HIT_OUT),
  .AUTO_PAGE_ENABLE_OUT(AUTO_PAGE_ENABLE_OUT),
  .IRQ_SOURCE_IN(IRQ_SOURCE_IN),
  .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT),
  .ACTIVE_PAGE_OUT(ACTIVE_PAGE_OUT)
);

//--- tb/cpu_sequencer.sv
`timescale 1ns/1ns
module cpu_sequencer (
  output logic entry_out = 1'h0,
  output logic [1:0] source_out = 2'h3,
  output logic [7:0] page_out = 8'h00,
  output logic return_out = 1'h0
);
  // qualifiers scrambled while no entry is requested
  task automatic drive(input logic e, r, input logic [1:0] s,
      input logic [7:0] p);
    entry_out = e;
    return_out = r;
    source_out = e ? s : ~source_out;
    page_out = e ? p : ~page_out;
  endtask
endmodule

//--- tb/page_context_stack_tb.sv
`timescale 1ns/1ns
module page_context_stack_tb;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, hit, en, ie, ir;
  logic [7:0] ad = 8'h00, wd = 8'h00, rd, act, pg;
  logic [1:0] src;
  int errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  cpu_sequencer cpu (.entry_out(ie), .source_out(src), .page_out(pg),
    .return_out(ir));
  page_context_stack dut (.CLOCK_IN(clk), .RST_IN(rst), .IRQ_ENTRY_IN(ie),
    .IRQ_SOURCE_IN(src), .IRQ_PAGE_IN(pg), .IRQ_RETURN_IN(ir),
    .REG_WRITE_IN(wr), .REG_ADDR_IN(ad), .REG_WDATA_IN(wd),
    .REG_RDATA_OUT(rd), .REG_HIT_OUT(hit), .ACTIVE_PAGE_OUT(act),
    .AUTO_PAGE_ENABLE_OUT(en));
  task automatic chk(input logic [7:0] g, x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  // o: entry, return, write
  task automatic sa(input logic [2:0] o, input logic [1:0] s,
      input logic [7:0] a, d, x);
    cpu.drive(o[2], o[1], s, d);
    wr = o[0];
    ad = a;
    wd = d;
    @(posedge clk) #1;
    chk(act, x);
  endtask
  task automatic rdc(input logic [7:0] a, x, input logic h);
    sa(3'h0, 2'h0, a, 8'h00, act);
    chk(rd, x);
    chk(hit, h);
  endtask
  task automatic t_reset;
    chk(en, 1'h1);
    rdc(8'h81, 8'h01, 1'h1);
    rdc(8'h84, 8'h00, 1'h1);
    rdc(8'h85, 8'h00, 1'h1);
    rdc(8'h86, 8'h00, 1'h1);
    rdc(8'h80, 8'h00, 1'h0);
  endtask
  task automatic t_nest;
    sa(3'h1, 2'h0, 8'h84, 8'h0f, 8'h0f);
    sa(3'h4, 2'h0, 8'h85, 8'h00, 8'h02);
    rdc(8'h85, 8'h0f, 1'h1);
    sa(3'h5, 2'h1, 8'h86, 8'h77, 8'h00);
    rdc(8'h85, 8'h02, 1'h1);
    rdc(8'h86, 8'h0f, 1'h1);
    sa(3'h2, 2'h0, 8'h85, 8'h00, 8'h02);
    rdc(8'h85, 8'h0f, 1'h1);
    rdc(8'h86, 8'h00, 1'h1);
    sa(3'h2, 2'h0, 8'h84, 8'h00, 8'h0f);
  endtask
  task automatic t_edit;
    sa(3'h4, 2'h2, 8'h84, 8'h3c, 8'h3c);
    sa(3'h1, 2'h0, 8'h85, 8'h55, 8'h3c);
    sa(3'h1, 2'h0, 8'h86, 8'h66, 8'h3c);
    rdc(8'h85, 8'h55, 1'h1);
    sa(3'h2, 2'h0, 8'h85, 8'h00, 8'h55);
    rdc(8'h85, 8'h66, 1'h1);
  endtask
  task automatic t_off;
    sa(3'h1, 2'h0, 8'h81, 8'hfe, 8'h55);
    chk(en, 1'h0);
    rdc(8'h81, 8'h00, 1'h1);
    sa(3'h4, 2'h0, 8'h84, 8'h00, 8'h55);
    sa(3'h2, 2'h0, 8'h84, 8'h00, 8'h55);
    sa(3'h1, 2'h0, 8'h81, 8'h01, 8'h55);
    chk(en, 1'h1);
    rdc(8'h81, 8'h01, 1'h1);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    t_reset();
    t_nest();
    t_edit();
    t_off();
    tally_and_finish();
  end
endmodule
